// ### design/pin_mux_pkg.sv
/*
 * Shared constants for the per-pin function multiplexer: pin numbering,
 * control byte layout, select codes, register offsets and bus answers.
 * Assumes a single clock domain and an AXI4-Lite register bus.
 */
package pin_mux_pkg;
	// =====================================================================
	// sizes
	localparam int NPINS = 30;
	localparam int CODE_W = 6;
	localparam int IRQ_LINES = 16;
	localparam int ADC01_CH = 8;
	localparam int ADC2_CH = 12;
	localparam int DAC_CH = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// =====================================================================
	// flat pin index of the first pin of each port
	localparam int P3_BASE = 0;
	localparam int P4_BASE = 6;
	localparam int P5_BASE = 14;
	localparam int P6_BASE = 20;
	localparam int P7_BASE = 26;

	// =====================================================================
	// control byte layout
	localparam int IRQ_INPUT_ENABLE_BIT = 6;
	localparam int ANALOG_INPUT_ENABLE_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [5:0] SEL_MASK_6 = 6'h3f;
	localparam logic [5:0] SEL_MASK_5 = 6'h1f;

	// =====================================================================
	// select codes
	localparam logic [5:0] CODE_HIZ = 6'h00;
	localparam logic [5:0] CODE_MTU = 6'h01;
	localparam logic [5:0] CODE_MTU_CLK = 6'h02;
	localparam logic [5:0] CODE_MTU_ALT = 6'h03;
	localparam logic [5:0] CODE_CLK_ALT = 6'h04;
	localparam logic [5:0] CODE_TMR8 = 6'h05;
	localparam logic [5:0] CODE_POE = 6'h07;
	localparam logic [5:0] CODE_SCI_A = 6'h0a;
	localparam logic [5:0] CODE_SCI_B = 6'h0b;
	localparam logic [5:0] CODE_SPI_SSL = 6'h0d;
	localparam logic [5:0] CODE_PWM_LO = 6'h14;
	localparam logic [5:0] CODE_PWM_HI = 6'h15;
	localparam logic [5:0] CODE_PWM_LO_ALT = 6'h16;
	localparam logic [5:0] CODE_PWM_HI_ALT = 6'h17;
	localparam logic [5:0] CODE_COMP = 6'h1e;

	// =====================================================================
	// register map: pin n control byte at 4*n, status word after them
	localparam logic [ADDR_W-1:0] CTRL_LAST_OFFSET = 8'h74;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h78;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ### design/port_pin_function_select.sv
/*
 * Per-pin function multiplexer for ports 3 to 7 with an AXI4-Lite slave.
 * Assumes pin levels on pin_in are synchronous to core_clk and that the
 * peripherals consume the registered routing outputs.
 */
// Implementation choices: the register offsets and register access over AXI4-Lite.
// Notes on behaviour
// - select field is bits 5..0 on newer variant, bits 4..0 on older.
// - code zero means high impedance; code one routes primary timer channel.
// - port3 pin3 newer: clock A, timer8 out0, slave select 3, pwm 3B pair.
// - port3 pin3 older: alternates on 3 and 4, 5 timer8, 13 slave select.
// - each pin with an interrupt line has an interrupt enable routing it to that line.
// - port3 pins 0,1 drive lines 7,6; newer pins 2..5 drive 12,13,3,6.
// - analog pins have an analog enable; one connects converter and comparator.
// - newer port4 pins feed converter channels 000..003 and 100..103.
// - older port5 pins 0..5 connect converter channels 206..211.
// - port6 pins 0..3 drive lines 4..7; newer pins 4,5 drive 8,9.
// - port6 analog: older 200..205, newer 206..211; pins 4,5 feed dacs; older variant keeps both dacs off.
// - port7 pin0: output disable 7, serial9 10, newer pwm triggers 20..23.
// - older port7 pins 1..3: timer 1, alternate 3, pwm 20, alternate 22.
// - newer port7 pins 1..3: pwm codes 20,22 and 21,23 for second set.
// - older variant alternate codes exist only on revision B silicon.
`timescale 1ns/1ps
module port_pin_function_select #(
	parameter bit NEWER_VARIANT = 1'b1,
	parameter bit REV_B = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pin_mux_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pin_mux_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [pin_mux_pkg::NPINS-1:0] pin_in,
	output logic [pin_mux_pkg::NPINS*pin_mux_pkg::CODE_W-1:0] pin_func_code,
	output logic [pin_mux_pkg::NPINS-1:0] pin_hiz,
	output logic [pin_mux_pkg::NPINS-1:0] pin_analog,
	output logic [pin_mux_pkg::IRQ_LINES-1:0] ext_interrupt_line,
	output logic [pin_mux_pkg::ADC01_CH-1:0] adc01_channel_enable,
	output logic [pin_mux_pkg::ADC2_CH-1:0] adc2_channel_enable,
	output logic [pin_mux_pkg::DAC_CH-1:0] dac_output_enable
);
	import pin_mux_pkg::*;

	// =====================================================================
	// pin capability tables
	localparam logic [5:0] SEL_MASK = NEWER_VARIANT ? SEL_MASK_6 : SEL_MASK_5;
	// alternate codes on the older part only exist on revision B silicon
	localparam bit ALT_OK = NEWER_VARIANT || REV_B;

	// interrupt line driven by a pin, -1 when the pin has none
	function automatic int irq_of(input int p);
		int r;
		r = -1;
		if (p == P3_BASE) r = 7;
		else if (p == P3_BASE + 1) r = 6;
		else if (NEWER_VARIANT && p == P3_BASE + 2) r = 12;
		else if (NEWER_VARIANT && p == P3_BASE + 3) r = 13;
		else if (NEWER_VARIANT && p == P3_BASE + 4) r = 3;
		else if (NEWER_VARIANT && p == P3_BASE + 5) r = 6;
		else if (p >= P6_BASE && p <= P6_BASE + 3) r = 4 + p - P6_BASE;
		else if (NEWER_VARIANT && (p == P6_BASE + 4 || p == P6_BASE + 5))
			r = 8 + p - (P6_BASE + 4);
		else if (p == P7_BASE) r = 5;
		return r;
	endfunction

	// analog capable pins live on ports 4, 5 and 6
	function automatic bit analog_cap(input int p);
		return (p >= P4_BASE && p < P7_BASE);
	endfunction

	// converter group 2 channel (200..211) fed by a pin, -1 when none
	function automatic int adc2_of(input int p);
		int r;
		int k;
		r = -1;
		k = 0;
		if (p >= P5_BASE && p < P6_BASE) begin
			k = p - P5_BASE;
			if (!NEWER_VARIANT) r = 6 + k;
			else if (k < 2) r = 4 + k;
			else r = k - 2;
		end else if (p >= P6_BASE && p < P7_BASE) begin
			k = p - P6_BASE;
			r = NEWER_VARIANT ? 6 + k : k;
		end
		return r;
	endfunction

	// bits that software can actually change in a pin's control byte
	function automatic logic [7:0] wmask(input int p);
		logic [7:0] m;
		m = {2'h0, SEL_MASK};
		if (irq_of(p) >= 0) m[IRQ_INPUT_ENABLE_BIT] = 1'b1;
		if (analog_cap(p)) m[ANALOG_INPUT_ENABLE_BIT] = 1'b1;
		return m;
	endfunction

	// is a select code listed for this pin on this variant
	function automatic bit code_legal(input int p, input logic [5:0] c);
		bit ok;
		bit base_ok;
		ok = 1'b0;
		// shared timer set of port 3 pins 0..3
		base_ok = (c == CODE_MTU || c == CODE_MTU_CLK || c == CODE_TMR8 ||
			c == CODE_SPI_SSL || (ALT_OK && (c == CODE_MTU_ALT || c == CODE_CLK_ALT)));
		if (p >= P3_BASE && p <= P3_BASE + 3) begin
			ok = base_ok;
			if (p == P3_BASE)
				ok = ok || c == CODE_COMP || (NEWER_VARIANT && (c == CODE_SCI_A ||
					c == CODE_SCI_B));
			if (NEWER_VARIANT && (p == P3_BASE + 2 || p == P3_BASE + 3))
				ok = ok || c == CODE_PWM_LO || c == CODE_PWM_LO_ALT;
		end else if (p == P7_BASE) begin
			ok = c == CODE_POE || c == CODE_SCI_A;
			if (NEWER_VARIANT)
				ok = ok || (c >= CODE_PWM_LO && c <= CODE_PWM_HI_ALT);
		end else if (p > P7_BASE) begin
			ok = c == CODE_MTU || c == CODE_PWM_LO ||
				(ALT_OK && (c == CODE_MTU_ALT || c == CODE_PWM_LO_ALT));
			if (NEWER_VARIANT)
				ok = ok || c == CODE_PWM_HI || c == CODE_PWM_HI_ALT;
		end
		return ok;
	endfunction

	// =====================================================================
	// register storage and bus state
	logic [7:0] ctrl_reg [NPINS];
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [NPINS*CODE_W-1:0] func_code_reg;
	logic [NPINS-1:0] hiz_reg;
	logic [NPINS-1:0] analog_reg;
	logic [IRQ_LINES-1:0] irq_reg;
	logic [ADC01_CH-1:0] adc01_reg;
	logic [ADC2_CH-1:0] adc2_reg;
	logic [DAC_CH-1:0] dac_reg;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic wr_mapped;
	logic rd_mapped;
	logic [ADDR_W-3:0] wr_idx;
	logic [ADDR_W-3:0] rd_idx;

	assign aw_take = s_axi_awvalid && awready_reg;
	assign w_take = s_axi_wvalid && wready_reg;
	assign ar_take = s_axi_arvalid && arready_reg;
	// write fires once both halves are held and no response is pending
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_idx = awaddr_reg[ADDR_W-1:2];
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];
	assign wr_mapped = awaddr_reg <= CTRL_LAST_OFFSET;
	assign rd_mapped = s_axi_araddr <= CTRL_LAST_OFFSET || s_axi_araddr == STATUS_OFFSET;

	// =====================================================================
	// write address and data capture, in either order
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else if (ce) begin
			// ready is a one-cycle pulse so each valid is taken exactly once
			awready_reg <= s_axi_awvalid && !awready_reg && !aw_held_reg;
			wready_reg <= s_axi_wvalid && !wready_reg && !w_held_reg;
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? RESP_OKAY : RESP_DECERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// control bytes; bits a pin lacks stay zero and read as zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < NPINS; p++) ctrl_reg[p] <= CTRL_RESET;
		end else if (ce) begin
			if (do_write && wr_mapped && wstrb0_reg) begin
				for (int p = 0; p < NPINS; p++) begin
					if (int'(wr_idx) == p) ctrl_reg[p] <= wdata_reg & wmask(p);
				end
			end
		end
	end

	// =====================================================================
	// read channel
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
		end else if (ce) begin
			arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
			if (ar_take) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rd_mapped ? RESP_OKAY : RESP_DECERR;
				rdata_reg <= '0;
				if (s_axi_araddr == STATUS_OFFSET) begin
					rdata_reg <= {{(DATA_W-NPINS){1'b0}}, hiz_reg};
				end else if (rd_mapped) begin
					for (int p = 0; p < NPINS; p++) begin
						if (int'(rd_idx) == p) rdata_reg <= {24'h000000, ctrl_reg[p]};
					end
				end
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// =====================================================================
	// digital function routing: reserved codes fall back to high impedance
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			func_code_reg <= '0;
			hiz_reg <= '1;
		end else if (ce) begin
			for (int p = 0; p < NPINS; p++) begin
				if (code_legal(p, ctrl_reg[p][CODE_W-1:0])) begin
					func_code_reg[p*CODE_W +: CODE_W] <= ctrl_reg[p][CODE_W-1:0];
					hiz_reg[p] <= 1'b0;
				end else begin
					func_code_reg[p*CODE_W +: CODE_W] <= CODE_HIZ;
					hiz_reg[p] <= 1'b1;
				end
			end
		end
	end

	// interrupt lines: pin level passes when its enable is set
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= '0;
		end else if (ce) begin
			for (int l = 0; l < IRQ_LINES; l++) begin
				irq_reg[l] <= 1'b0;
				for (int p = 0; p < NPINS; p++) begin
					if (irq_of(p) == l && ctrl_reg[p][IRQ_INPUT_ENABLE_BIT] && pin_in[p])
						irq_reg[l] <= 1'b1;
				end
			end
		end
	end

	// analog connections for converters, comparators and dacs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			analog_reg <= '0;
			adc01_reg <= '0;
			adc2_reg <= '0;
			dac_reg <= '0;
		end else if (ce) begin
			for (int p = 0; p < NPINS; p++) analog_reg[p] <= ctrl_reg[p][ANALOG_INPUT_ENABLE_BIT];
			for (int k = 0; k < ADC01_CH; k++)
				adc01_reg[k] <= ctrl_reg[P4_BASE + k][ANALOG_INPUT_ENABLE_BIT];
			for (int c = 0; c < ADC2_CH; c++) begin
				adc2_reg[c] <= 1'b0;
				for (int p = P5_BASE; p < P7_BASE; p++) begin
					if (adc2_of(p) == c && ctrl_reg[p][ANALOG_INPUT_ENABLE_BIT])
						adc2_reg[c] <= 1'b1;
				end
			end
			for (int d = 0; d < DAC_CH; d++)
				dac_reg[d] <= NEWER_VARIANT && ctrl_reg[P6_BASE + 4 + d][ANALOG_INPUT_ENABLE_BIT];
		end
	end

	// =====================================================================
	// outputs
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign pin_func_code = func_code_reg;
	assign pin_hiz = hiz_reg;
	assign pin_analog = analog_reg;
	assign ext_interrupt_line = irq_reg;
	assign adc01_channel_enable = adc01_reg;
	assign adc2_channel_enable = adc2_reg;
	assign dac_output_enable = dac_reg;
endmodule // port_pin_function_select

// ### testbench/pin_level_model.sv
/* package pin model: levels the bench asks for appear on pin_in.
   assumes levels settle one edge later, like synchronised pads. */
`timescale 1ns/1ps
module pin_level_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [29:0] want,
	output logic [29:0] pin_in
);
	// ==========================================
	// pins change only just after an edge, never at the sampling instant
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_in <= 30'h0;
		end else begin
			pin_in <= want;
		end
	end
endmodule // pin_level_model

// ### testbench/pin_mux_checker.sv
/* port checker for the pin function mux, either variant.
   assumes it is bound onto port_pin_function_select; ce low freezes all outputs together. */
`timescale 1ns/1ps
module pin_mux_checker #(
	parameter bit NEWER_VARIANT = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic [29:0] pin_in,
	input wire logic [179:0] pin_func_code,
	input wire logic [29:0] pin_hiz,
	input wire logic [29:0] pin_analog,
	input wire logic [15:0] ext_interrupt_line,
	input wire logic [7:0] adc01_channel_enable,
	input wire logic [11:0] adc2_channel_enable,
	input wire logic [1:0] dac_output_enable
);
	// ==========================================
	// routing relations
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_hiz_p33; pin_hiz[3] == (pin_func_code[23:18] == 6'h00); endproperty
	a_hiz_p33: assert property (p_hiz_p33) else $error("hiz disagrees with code");
	property p_no_digital; pin_hiz[25:4] == '1 && pin_func_code[155:24] == '0; endproperty
	a_no_digital: assert property (p_no_digital) else $error("analog-only pin routed");
	property p_no_analog; pin_analog[5:0] == 6'h00 && pin_analog[29:26] == 4'h0; endproperty
	a_no_analog: assert property (p_no_analog) else $error("analog on digital pin");
	property p_adc01; adc01_channel_enable == pin_analog[13:6]; endproperty
	a_adc01: assert property (p_adc01) else $error("converter 0/1 map wrong");
	// newer: port 6 onto 206..211, port 5 rotated onto 200..205; older: the ports swap
	property p_adc2;
		adc2_channel_enable == (NEWER_VARIANT ?
			{pin_analog[25:20], pin_analog[15:14], pin_analog[19:16]} :
			{pin_analog[19:14], pin_analog[25:20]});
	endproperty
	a_adc2: assert property (p_adc2) else $error("converter 2 map wrong");
	property p_dac; dac_output_enable == (NEWER_VARIANT ? pin_analog[25:24] : 2'h0); endproperty
	a_dac: assert property (p_dac) else $error("dac map wrong");
	// ==========================================
	// interrupt lines: a line may only rise from a mapped pin one cycle back
	property p_irq_unused; (ext_interrupt_line & 16'hcc07) == 16'h0000; endproperty
	a_irq_unused: assert property (p_irq_unused) else $error("unmapped line active");
	property p_ext_interrupt_line_7; ext_interrupt_line[7] |-> $past(pin_in[0] | pin_in[23]); endproperty
	a_ext_interrupt_line_7: assert property (p_ext_interrupt_line_7) else $error("line 7 without source");
	property p_irq13; ext_interrupt_line[13] |-> $past(pin_in[3]); endproperty
	a_irq13: assert property (p_irq13) else $error("line 13 without source");
	// only the status word, a mirror of pin_hiz, uses the upper read bits
	property p_rdata_byte;
		s_axi_rvalid |-> s_axi_rdata[31:30] == 2'h0 &&
			(s_axi_rdata[29:8] == 22'h000000 || s_axi_rdata[29:0] == pin_hiz);
	endproperty
	a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
endmodule // pin_mux_checker

bind port_pin_function_select pin_mux_checker #(.NEWER_VARIANT(NEWER_VARIANT)) chk (.core_clk,
	.rst, .s_axi_rdata,
	.s_axi_rvalid, .pin_in, .pin_func_code, .pin_hiz, .pin_analog, .ext_interrupt_line,
	.adc01_channel_enable, .adc2_channel_enable, .dac_output_enable);

// ### testbench/tb_top.sv
/* directed bench for the pin function mux over axi-lite.
   assumes a newer revision-b instance and an older revision-a twin share one bus. */
`timescale 1ns/1ps
module tb_top;
	import pin_mux_pkg::*;
	logic core_clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NPINS-1:0] want, pin_in, pin_hiz, pin_analog;
	logic [NPINS*CODE_W-1:0] pin_func_code;
	logic [IRQ_LINES-1:0] ext_interrupt_line;
	logic [ADC01_CH-1:0] adc01_channel_enable;
	logic [ADC2_CH-1:0] adc2_channel_enable;
	logic [DAC_CH-1:0] dac_output_enable;
	logic [NPINS*CODE_W-1:0] old_func_code;
	logic [NPINS-1:0] old_hiz;
	logic [IRQ_LINES-1:0] old_irq;
	logic [ADC2_CH-1:0] old_adc2;
	logic [DAC_CH-1:0] old_dac;
	logic [DATA_W-1:0] old_rdata;
	int failures, tests_run;
	// routed codes, then reserved ones (bit 6 marks an expected hiz)
	int tp [27] = '{3, 3, 3, 3, 3, 3, 3, 3, 26, 26, 26, 26, 26, 26, 27, 27, 27, 27, 27, 27,
		3, 3, 4, 27, 26, 3, 26};
	logic [6:0] tc [27] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h0d, 7'h14, 7'h16, 7'h07,
		7'h0a, 7'h14, 7'h15, 7'h16, 7'h17, 7'h01, 7'h03, 7'h14, 7'h15, 7'h16, 7'h17,
		7'h46, 7'h7f, 7'h41, 7'h42, 7'h41, 7'h40, 7'h40};
	int ip [8] = '{0, 1, 3, 4, 20, 24, 25, 26};
	int il [8] = '{7, 6, 13, 3, 4, 8, 9, 5};
	int ap [7] = '{6, 9, 14, 16, 24, 25, 3};
	logic [21:0] ae [7] = '{22'h000001, 22'h000008, 22'h001000, 22'h000100, 22'h140000,
		22'h280000, 22'h000000};
	// older part without revision b: which tc entries still route, and its analog map
	logic [26:0] old_ok = 27'h0014333;
	logic [13:0] oe [7] = '{14'h0000, 14'h0000, 14'h0040, 14'h0100, 14'h0010, 14'h0020,
		14'h0000};

	port_pin_function_select uut (.core_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_func_code,
		.pin_hiz, .pin_analog, .ext_interrupt_line, .adc01_channel_enable, .adc2_channel_enable,
		.dac_output_enable);
	// older variant on revision a silicon, same bus and pins, answers in lockstep
	port_pin_function_select #(.NEWER_VARIANT(1'b0), .REV_B(1'b0)) uut_old (.core_clk, .rst,
		.ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(old_rdata),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .pin_in,
		.pin_func_code(old_func_code), .pin_hiz(old_hiz), .pin_analog(),
		.ext_interrupt_line(old_irq), .adc01_channel_enable(), .adc2_channel_enable(old_adc2),
		.dac_output_enable(old_dac));
	pin_level_model pins (.core_clk, .rst, .want, .pin_in);

	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 1'b0;
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "write answer");
	endtask
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 40);
		s_axi_rready <= 1'b0;
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "read answer");
		chk(s_axi_rdata, ed, "read data");
	endtask
	// routing lags the write and pins lag the model, so let both land
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================
	// clock, watchdog and tests
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
	initial begin
		{rst, ce} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, want} = '0;
		failures = 0;
		tests_run = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		axi_read(STATUS_OFFSET, 32'h3fffffff, RESP_OKAY);
		axi_read(8'h0c, 32'h0, RESP_OKAY);
		for (int i = 0; i < 27; i++) begin
			axi_write(8'(tp[i] * 4), {25'h0, tc[i]} & 32'h3f, 4'hf, RESP_OKAY);
			settle();
			chk({26'h0, pin_func_code[tp[i]*6 +: 6]}, tc[i][6] ? 32'h0 : {26'h0, tc[i][5:0]},
				"routed code");
			chk({31'h0, pin_hiz[tp[i]]}, {31'h0, tc[i][6]}, "hiz");
			chk({26'h0, old_func_code[tp[i]*6 +: 6]}, old_ok[i] ? {26'h0, tc[i][5:0]} : 32'h0,
				"older code");
			chk({31'h0, old_hiz[tp[i]]}, {31'h0, ~old_ok[i]}, "older hiz");
			axi_read(8'(tp[i] * 4), {26'h0, tc[i][5:0]}, RESP_OKAY);
		end
		for (int i = 0; i < 8; i++) begin
			want <= 30'h1 << ip[i];
			settle();
			chk({16'h0, ext_interrupt_line}, 32'h0, "line while disabled");
			axi_write(8'(ip[i] * 4), 32'h40, 4'hf, RESP_OKAY);
			settle();
			chk({16'h0, ext_interrupt_line}, 32'h1 << il[i], "line map");
			chk({16'h0, old_irq}, (ip[i] inside {3, 4, 24, 25}) ? 32'h0 : 32'h1 << il[i],
				"older line map");
			@(posedge core_clk);
			want <= '0;
			settle();
			chk({16'h0, ext_interrupt_line}, 32'h0, "line follows pin");
			axi_write(8'(ip[i] * 4), 32'h0, 4'hf, RESP_OKAY);
		end
		// clock enable low freezes the routed line although the pin moves
		axi_write(8'h00, 32'h40, 4'hf, RESP_OKAY);
		ce <= 1'b0;
		want <= 30'h1;
		settle();
		chk({16'h0, ext_interrupt_line}, 32'h0, "line frozen by enable");
		@(posedge core_clk);
		ce <= 1'b1;
		settle();
		chk({16'h0, ext_interrupt_line}, 32'h80, "line after enable");
		@(posedge core_clk);
		want <= '0;
		axi_write(8'h00, 32'h0, 4'hf, RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			axi_write(8'(ap[i] * 4), 32'h80, 4'hf, RESP_OKAY);
			settle();
			chk({10'h0, dac_output_enable, adc2_channel_enable, adc01_channel_enable},
				{10'h0, ae[i]}, "analog map");
			chk({2'h0, pin_analog}, (ap[i] == 3) ? 32'h0 : 32'h1 << ap[i],
				"analog flag");
			chk({18'h0, old_dac, old_adc2}, {18'h0, oe[i]}, "older analog map");
			axi_read(8'(ap[i] * 4), (ap[i] == 3) ? 32'h0 : 32'h80, RESP_OKAY);
			axi_write(8'(ap[i] * 4), 32'h0, 4'hf, RESP_OKAY);
		end
		axi_write(8'h0c, 32'hffffffff, 4'hf, RESP_OKAY);
		axi_read(8'h0c, 32'h7f, RESP_OKAY);
		chk(old_rdata, 32'h1f, "older field width");
		axi_write(8'h0c, 32'h01, 4'he, RESP_OKAY);
		axi_read(8'h0c, 32'h7f, RESP_OKAY);
		axi_write(8'h0c, 32'h0, 4'hf, RESP_OKAY);
		axi_write(8'h7c, 32'h01, 4'hf, RESP_DECERR);
		axi_read(8'h7c, 32'h0, RESP_DECERR);
		axi_write(STATUS_OFFSET, 32'h0, 4'hf, RESP_DECERR);
		axi_read(STATUS_OFFSET, 32'h3fffffff, RESP_OKAY);
		print_verdict();
	end
endmodule // tb_top
